// ### rtl/host_rate_limiter.sv
// host port ingress policing and egress shaping with APB registers
//
// Behaviour
// - drop pri1 ingress at rate, bits 7:4
// - drop pri0 ingress at rate, bits 3:0
// - decode 4-bit code, 0000 unlimited
// - 10BT link ignores codes above 10 Mbps
// - shape egress pri3 by bits 15:12
// - shape egress pri2 by bits 11:8
// - shape egress pri1 by bits 7:4
// - shape egress pri0 by bits 3:0
// - egress holds frames back, never drops
// - single queue: only pri0 egress limited
// - optionally count 12 gap bytes
// - optionally count 8 preamble bytes
// - ingress mode selects counted frame kinds
`timescale 1ns/1ns
module host_rate_limiter
  import host_rate_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int CW       = 18
) (
  input  wire logic           CLK,
  input  wire logic           ARST_N,
  input  wire logic [15:0]    PADDR,
  input  wire logic           PSEL,
  input  wire logic           PENABLE,
  input  wire logic           PWRITE,
  input  wire logic [31:0]    PWDATA,
  input  wire logic [3:0]     PSTRB,
  output logic      [31:0]    PRDATA,
  output logic                PREADY,
  output logic                PSLVERR,
  input  wire ingress_frame_s ING_FRAME,
  output logic                ING_DONE,
  output logic                ING_DROP,
  input  wire egress_sent_s   EG_SENT,
  output logic      [3:0]     EG_ALLOW
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [15:0] host_ctrl;
  logic [15:0] host_ingress_rate_limits;
  logic [15:0] host_egress_rate_limits;
  logic [15:0] link_ctrl;
  logic [15:0] tick_count;
  logic        tick;
  logic [5:0]  exhausted;
  logic [3:0]  lim_code [6];
  logic [5:0]  lim_charge;
  logic [11:0] lim_bytes [6];
  logic [13:0] idx;
  logic        access;
  logic        wr_en;
  logic        link_10bt;
  logic        multi_queue;
  logic        count_ifg;
  logic        count_pre;
  logic [11:0] ing_bytes;
  logic [11:0] eg_bytes;
  logic        ing_counted;
  logic        ing_limited;
  logic        next_drop;

  function automatic logic reg_mapped(input logic [13:0] i);
    reg_mapped = (i == IDX_HOST_CTRL) || (i == IDX_INGRESS_LIMITS)
              || (i == IDX_EGRESS_LIMITS) || (i == IDX_LINK_CTRL)
              || (i == IDX_LIMIT_STATUS);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign idx         = PADDR[15:2];
  assign access      = PSEL && PENABLE;
  assign wr_en       = access && PREADY && PWRITE && (PADDR[1:0] == 2'b00);
  assign link_10bt   = link_ctrl[POS_LINK_10BT];
  assign multi_queue = link_ctrl[POS_MULTI_QUEUE];
  assign count_ifg   = host_ctrl[POS_COUNT_IFG];
  assign count_pre   = host_ctrl[POS_COUNT_PREAMBLE];

  // ------------------------------------------------------------
  // apb slave: one wait state, error on unmapped or unaligned
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= access && !PREADY;
      PSLVERR <= access && !PREADY && (!reg_mapped(idx) || PADDR[1:0] != 2'b00);
      if (access && !PREADY && !PWRITE && PADDR[1:0] == 2'b00) begin
        case (idx)
          IDX_HOST_CTRL:      PRDATA <= {16'h0000, host_ctrl};
          IDX_INGRESS_LIMITS: PRDATA <= {16'h0000, host_ingress_rate_limits};
          IDX_EGRESS_LIMITS:  PRDATA <= {16'h0000, host_egress_rate_limits};
          IDX_LINK_CTRL:      PRDATA <= {16'h0000, link_ctrl};
          IDX_LIMIT_STATUS:   PRDATA <= {26'h000_0000, exhausted};
          default:            PRDATA <= 32'h0000_0000;
        endcase
      end else if (access && !PREADY) begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      host_ctrl                <= RST_HOST_CTRL;
      host_ingress_rate_limits <= RST_INGRESS_LIMITS;
      host_egress_rate_limits  <= RST_EGRESS_LIMITS;
      link_ctrl                <= RST_LINK_CTRL;
    end else if (wr_en) begin
      case (idx)
        IDX_HOST_CTRL: begin
          host_ctrl <= merge(host_ctrl, PWDATA, PSTRB) & 16'h000f;
        end
        IDX_INGRESS_LIMITS: begin
          host_ingress_rate_limits <= merge(host_ingress_rate_limits, PWDATA, PSTRB);
        end
        IDX_EGRESS_LIMITS: begin
          host_egress_rate_limits <= merge(host_egress_rate_limits, PWDATA, PSTRB);
        end
        IDX_LINK_CTRL: begin
          link_ctrl <= merge(link_ctrl, PWDATA, PSTRB) & 16'h0003;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // replenish tick
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_count <= 16'h0000;
      tick       <= 1'b0;
    end else if (tick_count == 16'(TICK_LEN - 1)) begin
      tick_count <= 16'h0000;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 16'h0001;
      tick       <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // limiter codes: 0,1 ingress pri0/pri1; 2..5 egress pri0..pri3
  // ------------------------------------------------------------
  always_comb begin
    lim_code[0] = eff_code(host_ingress_rate_limits[POS_PRI0 +: 4], link_10bt);
    lim_code[1] = eff_code(host_ingress_rate_limits[POS_PRI1 +: 4], link_10bt);
    lim_code[2] = eff_code(host_egress_rate_limits[POS_PRI0 +: 4], link_10bt);
    lim_code[3] = eff_code(host_egress_rate_limits[POS_PRI1 +: 4], link_10bt);
    lim_code[4] = eff_code(host_egress_rate_limits[POS_PRI2 +: 4], link_10bt);
    lim_code[5] = eff_code(host_egress_rate_limits[POS_PRI3 +: 4], link_10bt);
    if (!multi_queue) begin
      lim_code[3] = CODE_UNLIMITED;
      lim_code[4] = CODE_UNLIMITED;
      lim_code[5] = CODE_UNLIMITED;
    end
  end

  // ------------------------------------------------------------
  // ingress classification and drop decision
  // ------------------------------------------------------------
  assign ing_bytes = frame_bytes(ING_FRAME.len, count_ifg, count_pre);
  assign eg_bytes  = frame_bytes(EG_SENT.len, count_ifg, count_pre);

  always_comb begin
    case (ingress_mode_e'(host_ctrl[POS_INGRESS_MODE +: 2]))
      MODE_ALL:       ing_counted = 1'b1;
      MODE_FLOODED:   ing_counted = ING_FRAME.bcast || ING_FRAME.mcast
                                 || ING_FRAME.flooded;
      MODE_MULTICAST: ing_counted = ING_FRAME.bcast || ING_FRAME.mcast;
      MODE_BROADCAST: ing_counted = ING_FRAME.bcast;
      default:        ing_counted = 1'b1;
    endcase
    ing_limited = ING_FRAME.valid && ing_counted && (ING_FRAME.prio < 2'd2);
    next_drop   = ing_limited && exhausted[ING_FRAME.prio[0]];
  end

  always_comb begin
    lim_charge[0] = ing_limited && !next_drop && (ING_FRAME.prio == 2'd0);
    lim_charge[1] = ing_limited && !next_drop && (ING_FRAME.prio == 2'd1);
    lim_bytes[0]  = ing_bytes;
    lim_bytes[1]  = ing_bytes;
    for (int q = 0; q < 4; q++) begin
      lim_charge[q + 2] = EG_SENT.valid && (EG_SENT.prio == 2'(q));
      lim_bytes[q + 2]  = eg_bytes;
    end
  end

  for (genvar i = 0; i < 6; i++) begin : g_bucket
    rate_bucket #(
      .CW           (CW)
    ) u_bucket (
      .clk          (CLK),
      .arst_n       (ARST_N),
      .tick         (tick),
      .code         (lim_code[i]),
      .charge       (lim_charge[i]),
      .charge_bytes (lim_bytes[i]),
      .exhausted    (exhausted[i])
    );
  end

  // ------------------------------------------------------------
  // frame path outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ING_DONE <= 1'b0;
      ING_DROP <= 1'b0;
    end else begin
      ING_DONE <= ING_FRAME.valid;
      ING_DROP <= next_drop;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EG_ALLOW <= 4'hf;
    end else begin
      EG_ALLOW <= ~exhausted[5:2];
    end
  end

endmodule

// ### rtl/host_rate_pkg.sv
// constants, types and helpers shared by the host port rate limiter
package host_rate_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [13:0] IDX_HOST_CTRL       = 14'h0546;
  localparam logic [13:0] IDX_INGRESS_LIMITS  = 14'h0548;
  localparam logic [13:0] IDX_EGRESS_LIMITS   = 14'h054a;
  localparam logic [13:0] IDX_LINK_CTRL       = 14'h054c;
  localparam logic [13:0] IDX_LIMIT_STATUS    = 14'h054e;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          POS_COUNT_PREAMBLE = 0;
  localparam int          POS_COUNT_IFG      = 1;
  localparam int          POS_INGRESS_MODE   = 2;
  localparam int          POS_LINK_10BT      = 0;
  localparam int          POS_MULTI_QUEUE    = 1;
  localparam int          POS_PRI0           = 0;
  localparam int          POS_PRI1           = 4;
  localparam int          POS_PRI2           = 8;
  localparam int          POS_PRI3           = 12;
  localparam logic [15:0] RST_HOST_CTRL      = 16'h0000;
  localparam logic [15:0] RST_INGRESS_LIMITS = 16'h0000;
  localparam logic [15:0] RST_EGRESS_LIMITS  = 16'h0000;
  localparam logic [15:0] RST_LINK_CTRL      = 16'h0002;

  // ------------------------------------------------------------
  // rate codes and byte overheads
  // ------------------------------------------------------------
  localparam logic [3:0]  CODE_UNLIMITED     = 4'h0;
  localparam logic [3:0]  CODE_MAX_10BT      = 4'h8;
  localparam logic [11:0] INTERFRAME_GAP_BYTES = 12'h00c;
  localparam logic [11:0] PREAMBLE_BYTES     = 12'h008;

  typedef enum logic [1:0] {
    MODE_ALL,
    MODE_FLOODED,
    MODE_MULTICAST,
    MODE_BROADCAST
  } ingress_mode_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  prio;
    logic [10:0] len;
    logic        bcast;
    logic        mcast;
    logic        flooded;
  } ingress_frame_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  prio;
    logic [10:0] len;
  } egress_sent_s;

  // bytes granted per tick for each code
  function automatic logic [15:0] rate_bytes(input logic [3:0] code);
    case (code)
      4'h1:    rate_bytes = 16'h0008;
      4'h2:    rate_bytes = 16'h0010;
      4'h3:    rate_bytes = 16'h0020;
      4'h4:    rate_bytes = 16'h0040;
      4'h5:    rate_bytes = 16'h007d;
      4'h6:    rate_bytes = 16'h00fa;
      4'h7:    rate_bytes = 16'h01f4;
      4'h8:    rate_bytes = 16'h03e8;
      4'h9:    rate_bytes = 16'h07d0;
      4'ha:    rate_bytes = 16'h0fa0;
      4'hb:    rate_bytes = 16'h1770;
      4'hc:    rate_bytes = 16'h1f40;
      4'hd:    rate_bytes = 16'h2328;
      4'he:    rate_bytes = 16'h2710;
      4'hf:    rate_bytes = 16'h2af8;
      default: rate_bytes = 16'h0000;
    endcase
  endfunction

  // codes above 10 Mbps fall back to unlimited on a 10BT link
  function automatic logic [3:0] eff_code(input logic [3:0] code, input logic link_10bt);
    eff_code = (link_10bt && code > CODE_MAX_10BT) ? CODE_UNLIMITED : code;
  endfunction

  // frame bytes plus optional gap and preamble
  function automatic logic [11:0] frame_bytes(input logic [10:0] len,
                                              input logic interframe_gap_bytes, input logic pre);
    frame_bytes = {1'b0, len} + (interframe_gap_bytes ? INTERFRAME_GAP_BYTES : 12'h000)
                + (pre ? PREAMBLE_BYTES : 12'h000);
  endfunction

endpackage

// ### rtl/rate_bucket.sv
// credit bucket for one priority limiter
`timescale 1ns/1ns
module rate_bucket
  import host_rate_pkg::*;
#(
  parameter int CW = 18
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        tick,
  input  wire logic [3:0]  code,
  input  wire logic        charge,
  input  wire logic [11:0] charge_bytes,
  output logic             exhausted
);

  logic signed [CW-1:0] credit;
  logic signed [CW-1:0] next_credit;
  logic signed [CW-1:0] cap;

  always_comb begin
    cap         = $signed(CW'({1'b0, rate_bytes(code)}));
    next_credit = credit;
    if (tick) begin
      next_credit = next_credit + cap;
    end
    if (charge) begin
      next_credit = next_credit - $signed(CW'({1'b0, charge_bytes}));
    end
    if (next_credit > cap) begin
      next_credit = cap;
    end
  end

  // ------------------------------------------------------------
  // credit replenished each tick, spent per frame
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      credit <= '0;
    end else if (code == CODE_UNLIMITED) begin
      credit <= '0;
    end else begin
      credit <= next_credit;
    end
  end

  assign exhausted = (code != CODE_UNLIMITED) && (credit <= 0);

endmodule

// ### tb/host_rate_asserts.sv
// port assertions for the host port rate limiter
`timescale 1ns/1ns
module host_rate_asserts
  import host_rate_pkg::*;
(
  input wire logic           CLK,
  input wire logic           ARST_N,
  input wire logic           PSEL,
  input wire logic           PENABLE,
  input wire logic [31:0]    PRDATA,
  input wire logic           PREADY,
  input wire logic           PSLVERR,
  input wire ingress_frame_s ING_FRAME,
  input wire logic           ING_DONE,
  input wire logic           ING_DROP,
  input wire logic [3:0]     EG_ALLOW
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_answer; !PREADY ##1 PREADY; endsequence
  a_apb_one_wait: assert property (s_setup |=> s_answer)
    else $error("apb answer not after one wait state");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("pready held too long");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("pslverr without pready");
  a_rdata_upper_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_ing_answer: assert property (ING_FRAME.valid |=> ING_DONE)
    else $error("frame without verdict");
  a_done_cause: assert property (ING_DONE |-> $past(ING_FRAME.valid))
    else $error("verdict without frame");
  a_drop_qualified: assert property (ING_DROP |-> ING_DONE)
    else $error("drop outside verdict");
  a_high_prio_pass: assert property (ING_DONE && $past(ING_FRAME.prio) >= 2'd2 |-> !ING_DROP)
    else $error("priority 2 or 3 frame dropped");
  a_allow_reset: assert property ($rose(ARST_N) |-> EG_ALLOW == 4'hf)
    else $error("egress not unlimited after reset");
endmodule

bind host_rate_limiter host_rate_asserts u_chk (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ING_FRAME(ING_FRAME), .ING_DONE(ING_DONE), .ING_DROP(ING_DROP), .EG_ALLOW(EG_ALLOW));

// ### tb/queue_model.sv
// host port egress queues feeding the shaper
`timescale 1ns/1ns
module queue_model
  import host_rate_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  eg_allow,
  input  wire logic [3:0]  backlog,
  input  wire logic [10:0] frame_len,
  output egress_sent_s     eg_sent,
  output logic      [63:0] sent_cnt
);
  logic [2:0] cnt;
  logic [1:0] q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 3'h0;
      q <= 2'h0;
      eg_sent <= '0;
      sent_cnt <= 64'h0;
    end else begin
      eg_sent <= '0;
      if (cnt != 3'h0) cnt <= cnt - 3'h1;
      if (cnt == 3'h4) begin
        eg_sent <= '{1'b1, q, frame_len};
        sent_cnt[q*16 +: 16] <= sent_cnt[q*16 +: 16] + 16'h1;
      end
      if (cnt == 3'h0) begin
        for (int i = 0; i < 4; i++) begin
          if (backlog[i] && eg_allow[i]) begin
            q <= 2'(i);
            cnt <= 3'h7;
          end
        end
      end
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the host port rate limiter
`timescale 1ns/1ns
module testbench
  import host_rate_pkg::*;
;
  localparam int T = 200;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, ing_done, ing_drop;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] allow, backlog;
  logic [10:0] qlen;
  logic [63:0] sent;
  ingress_frame_s ing;
  egress_sent_s eg;
  int cyc, fails, n_tests;
  int kb [1:15] = '{64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000,
                    32000, 48000, 64000, 72000, 80000, 88000};

  host_rate_limiter #(.TICK_LEN(T)) uut (.CLK(clk), .ARST_N(arst_n), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ING_FRAME(ing),
    .ING_DONE(ing_done), .ING_DROP(ing_drop), .EG_SENT(eg), .EG_ALLOW(allow));
  queue_model far (.clk(clk), .arst_n(arst_n), .eg_allow(allow), .backlog(backlog),
    .frame_len(qlen), .eg_sent(eg), .sent_cnt(sent));

  // ----------------------------------------
  // clock, cycle count, tasks
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk or negedge arst_n) cyc <= arst_n ? cyc + 1 : 0;

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rst;
    @(posedge clk);
    arst_n <= 0;
    repeat (5) @(posedge clk);
    arst_n <= 1;
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [13:0] i, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, {i, 2'b00}, {16'h0, d}, q, e);
  endtask
  task rd_chk(input logic [15:0] a, input logic [31:0] exp, input int x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, x);
  endtask
  task frame(input logic [1:0] p, input logic [2:0] f, input logic [10:0] n, output logic d);
    @(posedge clk);
    ing <= {1'b1, p, n, f};
    @(posedge clk);
    ing <= '0;
    @(posedge clk);
    chk({31'h0, ing_done}, 32'h1);
    d = ing_drop;
  endtask
  task run_ing(input int lk, input int p, input logic [15:0] lim,
               input int ctl, input int f, input int n, input int x);
    logic d;
    rst;
    wr(IDX_LINK_CTRL, 16'(lk));
    wr(IDX_HOST_CTRL, 16'(ctl));
    wr(IDX_INGRESS_LIMITS, lim);
    while (cyc < 2 * T + T / 2) @(posedge clk);
    frame(2'(p), 3'(f), 11'(n), d);
    frame(2'(p), 3'(f), 11'd1, d);
    chk({31'h0, d}, x);
  endtask
  // high codes: spend a full tick of credit in a 2000-byte frame, a 1-byte frame, then 500-byte frames
  task run_big(input int c);
    logic d;
    int r;
    run_ing(2, 0, 16'(c), 0, 0, 2000, 0);
    for (r = kb[c] / 8 - 2001; r > 0; r -= 500) begin
      frame(2'd0, 3'd0, 11'd500, d);
      chk({31'h0, d}, 32'h0);
    end
    frame(2'd0, 3'd0, 11'd500, d);
    chk({31'h0, d}, 32'h1);
  endtask
  task run_eg(input int lk, input logic [15:0] lim, input logic [3:0] x);
    rst;
    wr(IDX_LINK_CTRL, 16'(lk));
    wr(IDX_EGRESS_LIMITS, lim);
    repeat (4) @(posedge clk);
    chk({28'h0, allow}, {28'h0, x});
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, ing, backlog, qlen} = '0;
    rst;
    rd_chk({IDX_HOST_CTRL, 2'b00}, 32'h0, 0);
    rd_chk({IDX_INGRESS_LIMITS, 2'b00}, 32'h0, 0);
    rd_chk({IDX_EGRESS_LIMITS, 2'b00}, 32'h0, 0);
    rd_chk({IDX_LINK_CTRL, 2'b00}, 32'h2, 0);
    wr(IDX_LIMIT_STATUS, 16'hffff);
    rd_chk({IDX_LIMIT_STATUS, 2'b00}, 32'h0, 0);
    rd_chk(16'h1540, 32'h0, 1);
    rd_chk(16'h1522, 32'h0, 1);
    wr(IDX_INGRESS_LIMITS, 16'ha5c3);
    rd_chk({IDX_INGRESS_LIMITS, 2'b00}, 32'ha5c3, 0);
    rd_chk({IDX_LIMIT_STATUS, 2'b00}, 32'h3, 0);
    for (int c = 1; c <= 9; c++) begin
      run_ing(2, 0, 16'(c), 0, 0, 11'(kb[c] / 8 - 1), 0);
      run_ing(2, 0, 16'(c), 0, 0, 11'(kb[c] / 8), 1);
    end
    for (int c = 10; c <= 15; c++) begin
      run_big(c);
    end
    run_ing(2, 1, 16'h0040, 0, 0, 64, 1);
    run_ing(2, 1, 16'h0040, 0, 0, 63, 0);
    run_ing(2, 2, 16'hffff, 0, 0, 2047, 0);
    run_ing(2, 0, 16'h0004, 4'h1, 0, 56, 1);
    run_ing(2, 0, 16'h0004, 4'h1, 0, 55, 0);
    run_ing(2, 0, 16'h0004, 4'h2, 0, 52, 1);
    run_ing(2, 0, 16'h0004, 4'h2, 0, 51, 0);
    run_ing(2, 0, 16'h0004, 4'hc, 3'b100, 100, 1);
    run_ing(2, 0, 16'h0004, 4'hc, 3'b010, 100, 0);
    run_ing(2, 0, 16'h0004, 4'h8, 3'b010, 100, 1);
    run_ing(2, 0, 16'h0004, 4'h8, 3'b001, 100, 0);
    run_ing(2, 0, 16'h0004, 4'h4, 3'b001, 100, 1);
    run_ing(2, 0, 16'h0004, 4'h4, 3'b000, 100, 0);
    run_ing(3, 0, 16'h0009, 0, 0, 2047, 0);
    run_ing(3, 0, 16'h0008, 0, 0, 1000, 1);
    run_eg(2, 16'h1000, 4'h7);
    run_eg(2, 16'h0100, 4'hb);
    run_eg(2, 16'h0010, 4'hd);
    run_eg(2, 16'h0001, 4'he);
    run_eg(0, 16'h1111, 4'he);
    run_eg(3, 16'h9898, 4'ha);
    run_eg(2, 16'h1000, 4'h7);
    qlen <= 11'd64;
    backlog <= 4'hc;
    repeat (20 * T) @(posedge clk);
    backlog <= 4'h0;
    repeat (10) @(posedge clk);
    chk({31'h0, sent[63:48] >= 2 && sent[63:48] <= 4}, 32'h1);
    chk({31'h0, sent[47:32] > 16'd100}, 32'h1);
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    finish_test;
  end
endmodule
